/* verilog/cbw_io_window_irq_cfg.v */
// Purpose: i/o window base/limit and interrupt line/pin config registers
// Assumes: mode field and tie bit come from config registers elsewhere
// Notes:   register read data appear one cycle after the read strobe
`timescale 1ns/1ps
`include "cbw_consts.vh"

module cbw_io_window_irq_cfg #(
   parameter FUNC_NUM = 0,
   parameter CNT_W    = 16
) (
   input  wire        clk_in,
   input  wire        sys_rst_in,
   input  wire [7:0]  reg_addr_in,
   input  wire [31:0] reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output wire [31:0] reg_rdata_out,
   input  wire [1:0]  irq_signaling_mode_field_in,
   input  wire        irq_function_tie_bit_in,
   input  wire        pci_io_req_in,
   input  wire [31:0] pci_io_addr_in,
   output wire        pci_dec_valid_out,
   output wire        pci_to_cb_fwd_out,
   output wire [1:0]  pci_win_hit_out,
   input  wire        cb_io_req_in,
   input  wire [31:0] cb_io_addr_in,
   output wire        cb_dec_valid_out,
   output wire        cb_to_pci_fwd_out,
   output wire [1:0]  cb_win_hit_out,
   output wire [1:0]  io_win_en_out,
   output wire [7:0]  irq_routing_line_out,
   output wire [7:0]  irq_pin_value_out
);

   localparam NWIN = 2;

   // ****************************************************************
   // declarations
   // ****************************************************************
   reg  [31:0]         rdata_ff;
   reg  [31:0]         nxt_rdata;
   reg  [7:0]          irq_line_ff;
   reg  [7:0]          irq_pin_ff;
   reg  [7:0]          nxt_irq_pin;
   reg                 pci_valid_ff;
   reg                 pci_fwd_ff;
   reg  [1:0]          pci_hit_ff;
   reg                 cb_valid_ff;
   reg                 cb_fwd_ff;
   reg  [1:0]          cb_hit_ff;
   reg  [1:0]          pci_last_ff;
   reg  [1:0]          cb_last_ff;
   wire [NWIN*30-1:0]  base_flat;
   wire [NWIN*14-1:0]  limit_flat;
   wire [NWIN*CNT_W-1:0] cnt_flat;
   wire [NWIN-1:0]     win_en;
   wire [NWIN-1:0]     pci_hit;
   wire [NWIN-1:0]     cb_hit;
   wire                wr_line;
   wire                pci_any;
   wire                cb_any;
   wire [31:0]         base0_img;
   wire [31:0]         lim0_img;
   wire [31:0]         base1_img;
   wire [31:0]         lim1_img;
   wire [31:0]         irq_img;
   wire [31:0]         stat_img;
   wire [31:0]         cnt0_img;
   wire [31:0]         cnt1_img;

   // ****************************************************************
   // per-window registers, enables and comparators
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NWIN; gi = gi + 1) begin : g_win
         reg  [29:0]      base_ff;
         reg  [13:0]      limit_ff;
         reg  [CNT_W-1:0] cnt_ff;
         reg  [CNT_W-1:0] nxt_cnt;
         wire [7:0]       base_off;
         wire [7:0]       limit_off;
         wire [7:0]       cnt_off;
         wire             wr_base;
         wire             wr_limit;
         wire             wr_cnt;

         assign base_off  = (gi == 0) ? `CBW_OFF_WIN0_BASE :
                                        `CBW_OFF_WIN1_BASE;
         assign limit_off = (gi == 0) ? `CBW_OFF_WIN0_LIMIT :
                                        `CBW_OFF_WIN1_LIMIT;
         assign cnt_off   = (gi == 0) ? `CBW_OFF_HIT_CNT0 :
                                        `CBW_OFF_HIT_CNT1;
         assign wr_base   = reg_wr_in & (reg_addr_in == base_off);
         assign wr_limit  = reg_wr_in & (reg_addr_in == limit_off);
         assign wr_cnt    = reg_wr_in & (reg_addr_in == cnt_off);

         // bits 1..0 of base and limit, and limit 31..16, have no storage
         always @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               base_ff  <= `CBW_BASE_RST;
               limit_ff <= `CBW_LIMIT_RST;
            end else begin
               if (wr_base) begin
                  base_ff <= reg_wdata_in[31:2];
               end
               if (wr_limit) begin
                  limit_ff <= reg_wdata_in[15:2];
               end
            end
         end

         // all-zero window is off, so reset leaves pci-to-card forwarding closed
         assign win_en[gi] = (base_ff != `CBW_BASE_RST) |
                             (limit_ff != `CBW_LIMIT_RST);

         // ************************************************************
         // hit counters
         // ************************************************************
         // saturating hit counter; a hit in the clear cycle still counts
         always @* begin
            nxt_cnt = cnt_ff;
            if (wr_cnt) begin
               nxt_cnt = {CNT_W{1'b0}};
            end
            if (pci_io_req_in & pci_hit[gi] & (nxt_cnt != {CNT_W{1'b1}}))
            begin
               nxt_cnt = nxt_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end

         always @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               cnt_ff <= {CNT_W{1'b0}};
            end else begin
               cnt_ff <= nxt_cnt;
            end
         end

         assign base_flat[gi*30 +: 30]     = base_ff;
         assign limit_flat[gi*14 +: 14]    = limit_ff;
         assign cnt_flat[gi*CNT_W +: CNT_W] = cnt_ff;

         // ************************************************************
         // comparators
         // ************************************************************
         // one per direction so both buses decode in the same cycle
         cbw_window_cmp u_pci_cmp (
            .base_in   (base_ff),
            .limit_in  (limit_ff),
            .win_en_in (win_en[gi]),
            .addr_in   (pci_io_addr_in),
            .hit_out   (pci_hit[gi])
         );

         cbw_window_cmp u_cb_cmp (
            .base_in   (base_ff),
            .limit_in  (limit_ff),
            .win_en_in (win_en[gi]),
            .addr_in   (cb_io_addr_in),
            .hit_out   (cb_hit[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // forwarding decisions, registered one cycle after the request
   // ****************************************************************
   assign pci_any = |pci_hit;
   assign cb_any  = |cb_hit;

   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pci_valid_ff <= 1'b0;
         pci_fwd_ff   <= 1'b0;
         pci_hit_ff   <= 2'b00;
         cb_valid_ff  <= 1'b0;
         cb_fwd_ff    <= 1'b0;
         cb_hit_ff    <= 2'b00;
      end else begin
         pci_valid_ff <= pci_io_req_in;
         cb_valid_ff  <= cb_io_req_in;
         // pci i/o inside a window is claimed for the card side
         pci_fwd_ff   <= pci_io_req_in & pci_any;
         pci_hit_ff   <= pci_io_req_in ? pci_hit : 2'b00;
         // card i/o outside every window goes up to pci
         cb_fwd_ff    <= cb_io_req_in & ~cb_any;
         cb_hit_ff    <= cb_io_req_in ? cb_hit : 2'b00;
      end
   end

   // ****************************************************************
   // decode status
   // ****************************************************************
   // last decode result kept for status reads
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pci_last_ff <= 2'b00;
         cb_last_ff  <= 2'b00;
      end else begin
         if (pci_io_req_in) begin
            pci_last_ff <= pci_hit;
         end
         if (cb_io_req_in) begin
            cb_last_ff <= cb_hit;
         end
      end
   end

   // ****************************************************************
   // interrupt line
   // ****************************************************************
   assign wr_line = reg_wr_in & (reg_addr_in == `CBW_OFF_IRQ_WORD);

   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_line_ff <= `CBW_LINE_RST;
      end else if (wr_line) begin
         irq_line_ff <= reg_wdata_in[`CBW_LINE_HI:0];
      end
   end

   // ****************************************************************
   // interrupt pin value
   // ****************************************************************
   // every mode maps the same; the case keeps the mode decode explicit
   always @* begin
      if (irq_function_tie_bit_in) begin
         nxt_irq_pin = `CBW_PIN_INTA;
      end else begin
         case (irq_signaling_mode_field_in)
            `CBW_MODE_PAR_PCI,
            `CBW_MODE_PAR_IRQ,
            `CBW_MODE_SER_IRQ,
            `CBW_MODE_SER_ALL: begin
               nxt_irq_pin = (FUNC_NUM == 0) ? `CBW_PIN_INTA :
                                               `CBW_PIN_INTB;
            end
            default: begin
               nxt_irq_pin = `CBW_PIN_INTA;
            end
         endcase
      end
   end

   // pin shows its printed default for the first cycle after reset
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_pin_ff <= `CBW_PIN_RST;
      end else begin
         irq_pin_ff <= nxt_irq_pin;
      end
   end

   // ****************************************************************
   // read images, fixed bits tied to zero here
   // ****************************************************************
   assign base0_img = {base_flat[29:0], `CBW_DW_ZEROS};
   assign lim0_img  = {16'h0000, limit_flat[13:0], `CBW_DW_ZEROS};
   assign base1_img = {base_flat[59:30], `CBW_DW_ZEROS};
   assign lim1_img  = {16'h0000, limit_flat[27:14], `CBW_DW_ZEROS};
   assign irq_img   = {16'h0000, irq_pin_ff, irq_line_ff};
   assign stat_img  = {26'h0000000, cb_last_ff, pci_last_ff, win_en};
   assign cnt0_img  = {{(32-CNT_W){1'b0}}, cnt_flat[CNT_W-1:0]};
   assign cnt1_img  = {{(32-CNT_W){1'b0}}, cnt_flat[2*CNT_W-1:CNT_W]};

   // ****************************************************************
   // register read, data valid only in the cycle after the strobe
   // ****************************************************************
   always @* begin
      nxt_rdata = `CBW_UNMAPPED_RD;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `CBW_OFF_WIN0_BASE: begin
               nxt_rdata = base0_img;
            end
            `CBW_OFF_WIN0_LIMIT: begin
               nxt_rdata = lim0_img;
            end
            `CBW_OFF_WIN1_BASE: begin
               nxt_rdata = base1_img;
            end
            `CBW_OFF_WIN1_LIMIT: begin
               nxt_rdata = lim1_img;
            end
            `CBW_OFF_IRQ_WORD: begin
               nxt_rdata = irq_img;
            end
            `CBW_OFF_DEC_STAT: begin
               nxt_rdata = stat_img;
            end
            `CBW_OFF_HIT_CNT0: begin
               nxt_rdata = cnt0_img;
            end
            `CBW_OFF_HIT_CNT1: begin
               nxt_rdata = cnt1_img;
            end
            default: begin
               nxt_rdata = `CBW_UNMAPPED_RD;
            end
         endcase
      end
   end

   // ****************************************************************
   // read data register
   // ****************************************************************
   // zero outside the slot so a stale word never looks like an answer
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_ff <= `CBW_UNMAPPED_RD;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign reg_rdata_out        = rdata_ff;
   assign pci_dec_valid_out    = pci_valid_ff;
   assign pci_to_cb_fwd_out    = pci_fwd_ff;
   assign pci_win_hit_out      = pci_hit_ff;
   assign cb_dec_valid_out     = cb_valid_ff;
   assign cb_to_pci_fwd_out    = cb_fwd_ff;
   assign cb_win_hit_out       = cb_hit_ff;
   assign io_win_en_out        = win_en;
   assign irq_routing_line_out = irq_line_ff;
   assign irq_pin_value_out    = irq_pin_ff;

endmodule // cbw_io_window_irq_cfg

/* verilog/cbw_consts.vh */
// Purpose: constants for the cardbus i/o window and interrupt config block
// Assumes: byte addresses on an 8-bit register address port
// Notes:   definitions only
`ifndef CBW_CONSTS_VH
`define CBW_CONSTS_VH

// ****************************************************************
// register offsets (byte addresses, word aligned except the irq pin byte)
// ****************************************************************
`define CBW_OFF_WIN0_BASE   8'h2c
`define CBW_OFF_WIN0_LIMIT  8'h30
`define CBW_OFF_WIN1_BASE   8'h34
`define CBW_OFF_WIN1_LIMIT  8'h38
`define CBW_OFF_IRQ_WORD    8'h3c
`define CBW_OFF_IRQ_LINE    8'h3c
`define CBW_OFF_IRQ_PIN     8'h3d
`define CBW_OFF_DEC_STAT    8'hf0
`define CBW_OFF_HIT_CNT0    8'hf4
`define CBW_OFF_HIT_CNT1    8'hf8

// ****************************************************************
// field layout
// ****************************************************************
`define CBW_BASE_WR_HI      31
`define CBW_BASE_WR_LO      2
`define CBW_LIMIT_WR_HI     15
`define CBW_LIMIT_WR_LO     2
`define CBW_PAGE_HI         31
`define CBW_PAGE_LO         16
`define CBW_LINE_HI         7
`define CBW_PIN_LSB         8
`define CBW_PIN_MSB         15
`define CBW_DW_ONES         2'b11
`define CBW_DW_ZEROS        2'b00

// ****************************************************************
// reset values and fixed answers
// ****************************************************************
`define CBW_BASE_RST        30'h00000000
`define CBW_LIMIT_RST       14'h0000
`define CBW_LINE_RST        8'hff
`define CBW_PIN_RST         8'h03
`define CBW_PIN_INTA        8'h01
`define CBW_PIN_INTB        8'h02
`define CBW_UNMAPPED_RD     32'h00000000

// ****************************************************************
// interrupt signaling modes
// ****************************************************************
`define CBW_MODE_PAR_PCI    2'h0
`define CBW_MODE_PAR_IRQ    2'h1
`define CBW_MODE_SER_IRQ    2'h2
`define CBW_MODE_SER_ALL    2'h3

`endif

/* verilog/cbw_window_cmp.v */
// Purpose: address compare against one i/o window
// Assumes: base holds bits 31..2, limit holds bits 15..2
// Notes:   purely combinational, one per window and direction
`timescale 1ns/1ps
`include "cbw_consts.vh"

module cbw_window_cmp (
   input  wire [29:0] base_in,
   input  wire [13:0] limit_in,
   input  wire        win_en_in,
   input  wire [31:0] addr_in,
   output wire        hit_out
);

   wire [31:0] base_full;
   wire [15:0] top_full;
   wire        page_eq;
   wire        above_bot;
   wire        below_top;

   assign base_full = {base_in, `CBW_DW_ZEROS};
   // low limit bits count as ones so the top dword is inside
   assign top_full  = {limit_in, `CBW_DW_ONES};
   // page comes only from the base register
   assign page_eq   = addr_in[31:16] == base_full[31:16];
   assign above_bot = addr_in[15:0] >= base_full[15:0];
   assign below_top = addr_in[15:0] <= top_full;
   assign hit_out   = win_en_in & page_eq & above_bot & below_top;

endmodule // cbw_window_cmp

/* test/cbw_io_window_irq_cfg_sva.sv */
// Purpose: port assertions for the i/o window and irq config block
// Assumes: one clock, asynchronous active high reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`include "cbw_consts.vh"
module cbw_cfg_sva #(
   parameter FUNC_NUM = 0
) (
   input wire        clk_in,
   input wire        sys_rst_in,
   input wire [7:0]  reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire        reg_wr_in,
   input wire        reg_rd_in,
   input wire [31:0] reg_rdata_out,
   input wire        irq_function_tie_bit_in,
   input wire        pci_io_req_in,
   input wire        pci_dec_valid_out,
   input wire        pci_to_cb_fwd_out,
   input wire [1:0]  pci_win_hit_out,
   input wire        cb_dec_valid_out,
   input wire        cb_to_pci_fwd_out,
   input wire [1:0]  cb_win_hit_out,
   input wire [1:0]  io_win_en_out,
   input wire [7:0]  irq_routing_line_out,
   input wire [7:0]  irq_pin_value_out
);
   // ****************************************
   // port relations
   // ****************************************
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire is_base = reg_addr_in == `CBW_OFF_WIN0_BASE ||
                  reg_addr_in == `CBW_OFF_WIN1_BASE;
   wire is_lim  = reg_addr_in == `CBW_OFF_WIN0_LIMIT ||
                  reg_addr_in == `CBW_OFF_WIN1_LIMIT;
   AST_RD_SLOT: assert property (reg_rdata_out != 32'h0 |-> $past(reg_rd_in))
      else $error("read data outside the read slot");
   AST_BASE_LOW: assert property (
      reg_rd_in && is_base |=> reg_rdata_out[1:0] == 2'h0)
      else $error("base low bits not zero");
   AST_LIM_FIXED: assert property (
      reg_rd_in && is_lim |=>
      reg_rdata_out[31:16] == 16'h0 && reg_rdata_out[1:0] == 2'h0)
      else $error("limit fixed bits not zero");
   AST_LINE_WR: assert property (
      reg_wr_in && reg_addr_in == `CBW_OFF_IRQ_WORD |=>
      irq_routing_line_out == $past(reg_wdata_in[7:0]))
      else $error("line register missed a write");
   // first edge after release still shows the reset pin value
   AST_PIN: assert property (!$past(sys_rst_in) |->
      irq_pin_value_out == (($past(irq_function_tie_bit_in) ||
      FUNC_NUM == 0) ? 8'h01 : 8'h02))
      else $error("pin value wrong");
   AST_PCI_FWD: assert property (
      pci_to_cb_fwd_out == (pci_win_hit_out != 2'h0))
      else $error("pci forward disagrees with hits");
   AST_CB_FWD: assert property (
      cb_to_pci_fwd_out == (cb_dec_valid_out && cb_win_hit_out == 2'h0))
      else $error("cardbus forward disagrees with hits");
   AST_HIT_EN: assert property (
      (pci_win_hit_out & ~$past(io_win_en_out)) == 2'h0)
      else $error("disabled window hit");
   AST_PCI_ANS: assert property (pci_io_req_in |=> pci_dec_valid_out)
      else $error("pci request unanswered");
   AST_PCI_IDLE: assert property (
      !pci_dec_valid_out |-> pci_win_hit_out == 2'h0)
      else $error("hit without request");
   cover property (pci_to_cb_fwd_out && pci_win_hit_out == 2'h2);
   cover property (cb_to_pci_fwd_out);
   cover property (reg_rd_in && is_lim);
   cover property (irq_function_tie_bit_in && irq_pin_value_out == 8'h01);
endmodule // cbw_cfg_sva

bind cbw_io_window_irq_cfg cbw_cfg_sva #(.FUNC_NUM(FUNC_NUM)) u_sva (
   .clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
   .reg_rd_in, .reg_rdata_out, .irq_function_tie_bit_in, .pci_io_req_in,
   .pci_dec_valid_out, .pci_to_cb_fwd_out, .pci_win_hit_out,
   .cb_dec_valid_out, .cb_to_pci_fwd_out, .cb_win_hit_out,
   .io_win_en_out, .irq_routing_line_out, .irq_pin_value_out
);

/* test/cbw_io_initiator.sv */
// Purpose: far side model issuing pci and cardbus i/o decode requests
// Assumes: caller invokes drive right after a rising edge
// Notes:   idle address lines invert so a stale address never decodes
`timescale 1ns/1ps
module cbw_io_initiator (
   output reg        pci_req_out,
   output reg [31:0] pci_addr_out,
   output reg        cb_req_out,
   output reg [31:0] cb_addr_out
);
   initial begin
      pci_req_out = 1'b0;
      pci_addr_out = 32'h0;
      cb_req_out = 1'b0;
      cb_addr_out = 32'h0;
   end
   task drive(input logic pv, input logic [31:0] pa,
              input logic cv, input logic [31:0] ca);
      pci_req_out <= pv;
      pci_addr_out <= pv ? pa : ~pci_addr_out;
      cb_req_out <= cv;
      cb_addr_out <= cv ? ca : ~cb_addr_out;
   endtask
endmodule // cbw_io_initiator

/* test/cbw_io_window_irq_cfg_test.sv */
// Purpose: self-checking bench for the i/o window and irq config block
// Assumes: instance is function 1, one clock, async reset
// Notes:   expected reads and decodes queue up in issue order
`timescale 1ns/1ps
`include "cbw_consts.vh"
module cbw_io_window_irq_cfg_test;
   reg          clk_in, sys_rst_in, reg_wr_in, reg_rd_in, tie, rd_was;
   reg  [7:0]   reg_addr_in, line_m;
   reg  [31:0]  reg_wdata_in, seed, base_m [0:1], lim_m [0:1];
   reg  [1:0]   mode, last_p, last_c;
   reg  [15:0]  cnt_m [0:1];
   wire [31:0]  reg_rdata_out, pci_addr, cb_addr;
   wire         pci_req, cb_req, pci_v, pci_f, cb_v, cb_f;
   wire [1:0]   pci_h, cb_h, win_en;
   wire [7:0]   line_o, pin_o;
   integer      num_errors, checks_done, cyc, i, j;
   logic [31:0] rd_q [$];
   logic [2:0]  pq [$], cq [$];
   logic [31:0] av [0:6] = '{32'h12340100, 32'h123400fc, 32'h123401f3,
      32'h123401f4, 32'h12350100, 32'h00000013, 32'h00000014};
   cbw_io_initiator P (.pci_req_out(pci_req), .pci_addr_out(pci_addr),
      .cb_req_out(cb_req), .cb_addr_out(cb_addr));
   cbw_io_window_irq_cfg #(.FUNC_NUM(1)) DUT (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .irq_signaling_mode_field_in(mode), .irq_function_tie_bit_in(tie),
      .pci_io_req_in(pci_req), .pci_io_addr_in(pci_addr),
      .pci_dec_valid_out(pci_v), .pci_to_cb_fwd_out(pci_f),
      .pci_win_hit_out(pci_h), .cb_io_req_in(cb_req),
      .cb_io_addr_in(cb_addr), .cb_dec_valid_out(cb_v),
      .cb_to_pci_fwd_out(cb_f), .cb_win_hit_out(cb_h),
      .io_win_en_out(win_en), .irq_routing_line_out(line_o),
      .irq_pin_value_out(pin_o));
   // ****************************************
   // reference model and drivers
   // ****************************************
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic hit(input integer w, input [31:0] a);
      hit = (base_m[w] != 0 || lim_m[w] != 0) &&
         a[31:16] == base_m[w][31:16] && a[15:0] >= base_m[w][15:0] &&
         a[15:0] <= {lim_m[w][15:2], 2'b11};
   endfunction
   function automatic logic en(input integer w);
      en = base_m[w] != 0 || lim_m[w] != 0;
   endfunction
   function automatic [31:0] rexp(input [7:0] a);
      case (a)
         `CBW_OFF_WIN0_BASE:  rexp = base_m[0];
         `CBW_OFF_WIN0_LIMIT: rexp = lim_m[0];
         `CBW_OFF_WIN1_BASE:  rexp = base_m[1];
         `CBW_OFF_WIN1_LIMIT: rexp = lim_m[1];
         `CBW_OFF_IRQ_WORD:   rexp = {16'h0, tie ? 8'h01 : 8'h02, line_m};
         `CBW_OFF_DEC_STAT:   rexp = {26'h0, last_c, last_p, en(1), en(0)};
         `CBW_OFF_HIT_CNT0:   rexp = {16'h0, cnt_m[0]};
         `CBW_OFF_HIT_CNT1:   rexp = {16'h0, cnt_m[1]};
         default:             rexp = 32'h0;
      endcase
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one cycle of bus and decode traffic; every call owns one edge
   task step(input w, input r, input [7:0] a, input [31:0] d,
             input q, input [31:0] qa);
      @(posedge clk_in);
      reg_wr_in <= w;
      reg_rd_in <= r;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      P.drive(q, qa, q, qa);
      if (q) pq.push_back({hit(0, qa) | hit(1, qa), hit(1, qa), hit(0, qa)});
      if (q) cq.push_back({~(hit(0, qa) | hit(1, qa)), hit(1, qa), hit(0, qa)});
      if (r) rd_q.push_back(rexp(a));
      if (w && a == `CBW_OFF_WIN0_BASE) base_m[0] = d & 32'hfffffffc;
      if (w && a == `CBW_OFF_WIN1_BASE) base_m[1] = d & 32'hfffffffc;
      if (w && a == `CBW_OFF_WIN0_LIMIT) lim_m[0] = d & 32'h0000fffc;
      if (w && a == `CBW_OFF_WIN1_LIMIT) lim_m[1] = d & 32'h0000fffc;
      if (w && a == `CBW_OFF_IRQ_WORD) line_m = d[7:0];
      if (q) begin
         last_p = {hit(1, qa), hit(0, qa)};
         last_c = last_p;
         cnt_m[0] = cnt_m[0] + hit(0, qa);
         cnt_m[1] = cnt_m[1] + hit(1, qa);
      end
      if (w && a == `CBW_OFF_HIT_CNT0) cnt_m[0] = 0;
      if (w && a == `CBW_OFF_HIT_CNT1) cnt_m[1] = 0;
   endtask
   task rd_all;
      for (i = 0; i < 8; i = i + 1) step(0, 1, 8'(44 + 4 * i), 0, 0, 0);
      step(0, 1, 8'h3d, 0, 0, 0);
      for (i = 0; i < 3; i = i + 1) step(0, 1, 8'(240 + 4 * i), 0, 0, 0);
   endtask
   task end_sim;
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************
   // result monitor, clock, timeout
   // ****************************************
   always @(negedge clk_in) begin
      if (rd_was) check(reg_rdata_out, rd_q.pop_front());
      if (pci_v === 1'b1) check({pci_f, pci_h}, pq.pop_front());
      if (cb_v === 1'b1) check({cb_f, cb_h}, cq.pop_front());
      rd_was = reg_rd_in;
   end
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc = cyc + 1;
      if (cyc > 5000) begin
         num_errors = num_errors + 1;
         end_sim;
      end
   end
   // ****************************************
   // main sequence, run twice for a mid-run reset
   // ****************************************
   initial begin
      num_errors = 0;
      checks_done = 0;
      cyc = 0;
      rd_was = 1'b0;
      seed = 32'h76b2;
      {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 0;
      mode = `CBW_MODE_SER_ALL;
      tie = 1'b0;
      sys_rst_in = 1'b1;
      for (j = 0; j < 2; j = j + 1) begin
         @(posedge clk_in);
         sys_rst_in <= 1'b1;
         {base_m[0], base_m[1], lim_m[0], lim_m[1]} = 0;
         {cnt_m[0], cnt_m[1], last_p, last_c} = 0;
         line_m = 8'hff;
         repeat (4) @(posedge clk_in);
         check({14'h0, win_en, pin_o, line_o}, 32'h03ff);
         sys_rst_in <= 1'b0;
         rd_all;
         step(1, 0, 8'h3d, 32'hffffffff, 0, 0);
         step(1, 0, 8'h40, 32'hffffffff, 0, 1'b1);
         step(0, 0, 0, 0, 1, 0);
         for (i = 0; i < 5; i = i + 1)
            step(1, 0, 8'(44 + 4 * i), 32'hffffffff, 0, 0);
         rd_all;
         step(1, 0, `CBW_OFF_WIN0_BASE, 32'h12340103, 0, 0);
         step(1, 0, `CBW_OFF_WIN0_LIMIT, 32'hffff01f3, 0, 0);
         step(1, 0, `CBW_OFF_WIN1_BASE, 32'h0, 0, 0);
         step(1, 0, `CBW_OFF_WIN1_LIMIT, 32'h10, 0, 0);
         step(0, 1, `CBW_OFF_WIN1_LIMIT, 0, 0, 0);
         for (i = 0; i < 7; i = i + 1) step(0, 0, 0, 0, 1, av[i]);
         check({30'h0, win_en}, 32'h3);
         for (i = 0; i < 16; i = i + 1) begin
            seed = lfsr(seed);
            step(1, 0, 8'h2c + {seed[5:4], 2'b00}, seed, 0, 0);
            step(0, 1, 8'h2c + {seed[5:4], 2'b00}, 0, 0, 0);
            seed = lfsr(seed);
            step(0, 0, 0, 0, 1, {base_m[seed[8]][31:16], seed[15:0]});
         end
         rd_all;
         step(1, 0, `CBW_OFF_HIT_CNT0, 0, 0, 0);
         step(1, 0, `CBW_OFF_HIT_CNT1, 0, 0, 0);
         step(0, 1, `CBW_OFF_HIT_CNT1, 0, 0, 0);
         for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            step(1, 0, `CBW_OFF_IRQ_WORD, seed, 0, 0);
            tie <= i[2];
            mode <= i[1:0];
            step(0, 1, `CBW_OFF_IRQ_WORD, 0, 0, 0);
         end
         step(0, 0, 0, 0, 0, 0);
      end
      repeat (3) step(0, 0, 0, 0, 0, 0);
      check(rd_q.size() + pq.size() + cq.size(), 0);
      end_sim;
   end
endmodule // cbw_io_window_irq_cfg_test
